// >>> src/temp_regs_pkg.sv
// shared constants of the temperature sensor register block
// assumes a 100 MHz system clock and eight-bit command bytes
package temp_regs_pkg;

	// widths of the register port and of the temperature words
	localparam int DATA_W = 8;
	localparam int TEMP_W = 12;
	localparam int SRES_W = 11;
	localparam int URES_W = 11;

	// command byte locations
	localparam logic [7:0] OFF_COMMON_STATUS = 8'h02;
	localparam logic [7:0] OFF_CONFIG = 8'h03;
	localparam logic [7:0] OFF_CONV_ENABLE = 8'h05;
	localparam logic [7:0] OFF_FILTER = 8'h06;
	localparam logic [7:0] OFF_DIODE_FAULT = 8'h07;
	localparam logic [7:0] OFF_ONESHOT = 8'h0f;

	// power-on values
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h1f;
	localparam logic [7:0] FILTER_RESET = 8'h0f;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// field positions
	localparam int CFG_STANDBY_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_NR_BIT = 6;
	localparam int FILT_R1_LSB = 0;
	localparam int FILT_R2_LSB = 2;
	localparam int FAULT_R1_SHORT = 0;
	localparam int FAULT_R1_OPEN = 1;
	localparam int FAULT_R2_SHORT = 2;
	localparam int FAULT_R2_OPEN = 3;

	// filter field codes; 2'b10 is reserved
	localparam logic [1:0] FILT_OFF = 2'h0;
	localparam logic [1:0] FILT_BASIC = 2'h1;
	localparam logic [1:0] FILT_ENHANCED = 2'h3;

	// channel numbers used by the sequencer
	localparam logic [1:0] CH_LOCAL = 2'h0;
	localparam logic [1:0] CH_REMOTE_ONE = 2'h1;
	localparam logic [1:0] CH_REMOTE_TWO = 2'h2;

	// readings substituted while a diode fault stands
	localparam logic [SRES_W-1:0] SIGNED_FAULT_RESULT = 11'h400;
	localparam logic [URES_W-1:0] UNSIGNED_FAULT_RESULT = 11'h000;

	// timing
	localparam int CLK_FREQ_KHZ = 100000;
	localparam int INIT_TIME_MS = 30;
	localparam int INIT_CYCLES = INIT_TIME_MS * CLK_FREQ_KHZ;
	localparam int CONV_TIME_MS = 10;
	localparam int CONV_CYCLES = CONV_TIME_MS * CLK_FREQ_KHZ;

endpackage

// >>> src/reg_access_bridge.sv
// toggle handshake carrying one register command from the link clock
// into the system clock and the read answer back
// assumes the link side keeps its request fields steady while it asks
`timescale 1ns/1ps

module reg_access_bridge (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic link_req,
	input wire logic link_write,
	input wire logic [temp_regs_pkg::DATA_W-1:0] link_cmd,
	input wire logic [temp_regs_pkg::DATA_W-1:0] link_wdata,
	output logic link_busy,
	output logic link_done,
	output logic [temp_regs_pkg::DATA_W-1:0] link_rdata,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [temp_regs_pkg::DATA_W-1:0] cmd_addr,
	output logic [temp_regs_pkg::DATA_W-1:0] cmd_wdata,
	input wire logic [temp_regs_pkg::DATA_W-1:0] cmd_rdata
);
	import temp_regs_pkg::*;

	typedef struct packed {
		logic req_tog;
		logic write;
		logic [DATA_W-1:0] cmd;
		logic [DATA_W-1:0] wdata;
		logic busy;
		logic ack_s1;
		logic ack_s2;
		logic done;
		logic [DATA_W-1:0] rdata;
	} link_state_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic valid;
		logic write;
		logic [DATA_W-1:0] cmd;
		logic [DATA_W-1:0] wdata;
		logic ack_tog;
		logic [DATA_W-1:0] resp;
	} sys_state_t;

	link_state_t link_reg, link_next;
	sys_state_t sys_reg, sys_next;

	// link side: one request in flight, later requests are dropped
	always_comb begin
		link_next = link_reg;
		link_next.ack_s1 = sys_reg.ack_tog;
		link_next.ack_s2 = link_reg.ack_s1;
		link_next.done = 1'b0;
		if (link_reg.busy) begin
			if (link_reg.ack_s2 == link_reg.req_tog) begin
				link_next.busy = 1'b0;
				link_next.done = 1'b1;
				link_next.rdata = sys_reg.resp; // steady until next request
			end
		end else if (link_req) begin
			link_next.req_tog = ~link_reg.req_tog;
			link_next.write = link_write;
			link_next.cmd = link_cmd;
			link_next.wdata = link_wdata;
			link_next.busy = 1'b1;
		end
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	// system side: payload is read only after the toggle has settled
	always_comb begin
		sys_next = sys_reg;
		sys_next.req_s1 = link_reg.req_tog;
		sys_next.req_s2 = sys_reg.req_s1;
		sys_next.req_s3 = sys_reg.req_s2;
		sys_next.valid = 1'b0;
		if (sys_reg.req_s2 != sys_reg.req_s3) begin
			sys_next.valid = 1'b1;
			sys_next.write = link_reg.write;
			sys_next.cmd = link_reg.cmd;
			sys_next.wdata = link_reg.wdata;
		end
		if (sys_reg.valid) begin
			sys_next.resp = cmd_rdata;
			sys_next.ack_tog = ~sys_reg.ack_tog;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sys_reg <= '0;
		end else begin
			sys_reg <= sys_next;
		end
	end

	assign link_busy = link_reg.busy;
	assign link_done = link_reg.done;
	assign link_rdata = link_reg.rdata;
	assign cmd_valid = sys_reg.valid;
	assign cmd_write = sys_reg.write;
	assign cmd_addr = sys_reg.cmd;
	assign cmd_wdata = sys_reg.wdata;

endmodule

// >>> src/conversion_sequencer.sv
// walks the enabled channels in order, local first, one timed slot each
// assumes the analog front end follows chan while busy is high
`timescale 1ns/1ps

module conversion_sequencer #(
	parameter int CONV_CYCLES = temp_regs_pkg::CONV_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic continuous,
	input wire logic [2:0] enables,
	output logic busy,
	output logic [1:0] chan,
	output logic done
);
	import temp_regs_pkg::*;

	localparam int CW = $clog2(CONV_CYCLES + 1);

	typedef enum logic {SEQ_IDLE, SEQ_CONVERT} seq_phase_t;

	typedef struct packed {
		seq_phase_t phase;
		logic [CW-1:0] cnt;
		logic [1:0] chan;
		logic busy;
		logic done;
	} seq_state_t;

	seq_state_t seq_reg, seq_next;

	// lowest enabled channel at or above from; msb flags a hit
	function automatic logic [2:0] pick_channel(input logic [2:0] en,
			input logic [1:0] from);
		logic [2:0] pick;
		pick = 3'h0;
		for (int i = 2; i >= 0; i--) begin
			if (en[i] && (i >= int'(from))) begin
				pick = {1'b1, 2'(i)};
			end
		end
		return pick;
	endfunction

	// disabled channels are never given a slot
	always_comb begin
		logic [2:0] pk;
		pk = 3'h0;
		seq_next = seq_reg;
		seq_next.done = 1'b0;
		case (seq_reg.phase)
			SEQ_IDLE: begin
				if (start || continuous) begin
					pk = pick_channel(enables, CH_LOCAL);
					if (pk[2]) begin
						seq_next.phase = SEQ_CONVERT;
						seq_next.chan = pk[1:0];
						seq_next.cnt = CW'(CONV_CYCLES - 1);
						seq_next.busy = 1'b1;
					end
				end
			end
			SEQ_CONVERT: begin
				if (seq_reg.cnt == '0) begin
					seq_next.done = 1'b1;
					if (seq_reg.chan != CH_REMOTE_TWO) begin
						pk = pick_channel(enables, seq_reg.chan + 2'h1);
					end
					if (pk[2]) begin
						seq_next.chan = pk[1:0];
						seq_next.cnt = CW'(CONV_CYCLES - 1);
					end else begin
						seq_next.phase = SEQ_IDLE;
						seq_next.busy = 1'b0;
					end
				end else begin
					seq_next.cnt = seq_reg.cnt - 1'b1;
				end
			end
			default: begin
				seq_next.phase = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_reg <= '0;
		end else begin
			seq_reg <= seq_next;
		end
	end

	assign busy = seq_reg.busy;
	assign chan = seq_reg.chan;
	assign done = seq_reg.done;

endmodule

// >>> src/temp_sensor_filter_status_regs.sv
// register control and status of a three-channel temperature sensor:
// filter selection, standby and one-shot, channel enables, common status,
// diode fault status and fault substitution of the remote readings
// assumes a two-wire protocol engine on link_clk hands over decoded
// command bytes, and a converter delivers measured_temp with each slot end
`timescale 1ns/1ps

// Behaviour
// - remote two filter field: 00 off, 01 basic, 11 enhanced; resets enhanced.
// - remote one filter field in low bits uses the same encoding.
// - one-shot write starts one pass over enabled channels, only in standby.
// - one-shot data is ignored and not stored; location is write-only.
// - common status bit 7 reads one while a conversion runs.
// - common status bit 6 reads one during the 30 ms power-up init.
// - common status bits 0 to 3 are the OR of status registers one to four.
// - fault bit 3 flags remote two open, bit 1 remote one open.
// - fault bit 2 flags remote two short, bit 0 remote one short.
// - positive input at ground or negative is short; at supply or float open.
// - during a diode fault readings show 0 unsigned and -128 signed.
// - configuration bit 6 selects standby; zero means continuous conversion.
// - disabled channels are skipped in every pass, one-shot included.
module temp_sensor_filter_status_regs #(
	parameter int INIT_CYCLES = temp_regs_pkg::INIT_CYCLES,
	parameter int CONV_CYCLES = temp_regs_pkg::CONV_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic link_req,
	input wire logic link_write,
	input wire logic [temp_regs_pkg::DATA_W-1:0] link_cmd,
	input wire logic [temp_regs_pkg::DATA_W-1:0] link_wdata,
	output logic link_busy,
	output logic link_done,
	output logic [temp_regs_pkg::DATA_W-1:0] link_rdata,
	input wire logic remote_one_short_sense,
	input wire logic remote_one_open_sense,
	input wire logic remote_two_short_sense,
	input wire logic remote_two_open_sense,
	input wire logic signed [temp_regs_pkg::TEMP_W-1:0] measured_temp,
	input wire logic [2:0] crit_one_status,
	input wire logic [2:0] crit_two_status,
	input wire logic [2:0] crit_three_status,
	output logic conv_busy,
	output logic [1:0] conv_channel,
	output logic low_power_hold_bit,
	output logic powerup_init_pending,
	output logic [1:0] remote_one_filter_select,
	output logic [1:0] remote_two_filter_select,
	output logic signed [temp_regs_pkg::SRES_W-1:0] remote_one_signed_result,
	output logic [temp_regs_pkg::URES_W-1:0] remote_one_unsigned_result,
	output logic signed [temp_regs_pkg::SRES_W-1:0] remote_two_signed_result,
	output logic [temp_regs_pkg::URES_W-1:0] remote_two_unsigned_result
);
	import temp_regs_pkg::*;

	localparam int IW = $clog2(INIT_CYCLES + 1);

	typedef struct packed {
		logic [3:0] sense_s1;
		logic [3:0] sense_s2;
		logic [IW-1:0] init_cnt;
		logic init_pending;
		logic standby;
		logic [2:0] enables;
		logic [3:0] filter;
		logic [3:0] fault;
		logic [3:0] summary;
		logic [1:0] last_chan;
		logic [SRES_W-1:0] r1_signed;
		logic [URES_W-1:0] r1_unsigned;
		logic [SRES_W-1:0] r2_signed;
		logic [URES_W-1:0] r2_unsigned;
	} regs_state_t;

	regs_state_t st_reg, st_next;

	logic cmd_valid;
	logic cmd_write;
	logic [DATA_W-1:0] cmd_addr;
	logic [DATA_W-1:0] cmd_wdata;
	logic [DATA_W-1:0] read_data;
	logic oneshot_start;
	logic seq_busy;
	logic [1:0] seq_chan;
	logic seq_done;

	// sense pair is {open, short}; short wins when both stand, since a
	// grounded input can also trip the open comparator
	function automatic logic [1:0] classify(input logic [1:0] sense);
		return {sense[1] & ~sense[0], sense[0]};
	endfunction

	// signed reading, clamped to the eleven-bit range
	function automatic logic [SRES_W-1:0] signed_reading(
			input logic signed [TEMP_W-1:0] t, input logic bad);
		logic [SRES_W-1:0] r;
		if (bad) begin
			r = SIGNED_FAULT_RESULT;
		end else if (t > 12'sh3ff) begin
			r = 11'h3ff;
		end else if (t < -12'sh400) begin
			r = 11'h400;
		end else begin
			r = t[SRES_W-1:0];
		end
		return r;
	endfunction

	// unsigned reading; below zero the word cannot go, so it pins at zero
	function automatic logic [URES_W-1:0] unsigned_reading(
			input logic signed [TEMP_W-1:0] t, input logic bad);
		logic [URES_W-1:0] r;
		if (bad || t < 12'sh000) begin
			r = UNSIGNED_FAULT_RESULT;
		end else begin
			r = t[URES_W-1:0];
		end
		return r;
	endfunction

	// command bytes from the link arrive here as one-cycle strobes
	reg_access_bridge bridge (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.link_clk(link_clk),
		.link_req(link_req),
		.link_write(link_write),
		.link_cmd(link_cmd),
		.link_wdata(link_wdata),
		.link_busy(link_busy),
		.link_done(link_done),
		.link_rdata(link_rdata),
		.cmd_valid(cmd_valid),
		.cmd_write(cmd_write),
		.cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata),
		.cmd_rdata(read_data)
	);

	// one-shot only counts in standby and after init; its data is dropped
	assign oneshot_start = cmd_valid && cmd_write
		&& (cmd_addr == OFF_ONESHOT)
		&& st_reg.standby && !st_reg.init_pending;

	// continuous running only once init is over and standby is clear
	conversion_sequencer #(
		.CONV_CYCLES(CONV_CYCLES)
	) sequencer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(oneshot_start),
		.continuous(!st_reg.standby && !st_reg.init_pending),
		.enables(st_reg.enables),
		.busy(seq_busy),
		.chan(seq_chan),
		.done(seq_done)
	);

	// next state and the read answer
	always_comb begin
		st_next = st_reg;
		read_data = 8'h00;

		// diode sense pins are asynchronous to sys_clk
		st_next.sense_s1 = {remote_two_open_sense, remote_two_short_sense,
			remote_one_open_sense, remote_one_short_sense};
		st_next.sense_s2 = st_reg.sense_s1;
		st_next.last_chan = seq_chan;

		// power-up init countdown
		if (st_reg.init_pending) begin
			if (st_reg.init_cnt == '0) begin
				st_next.init_pending = 1'b0;
			end else begin
				st_next.init_cnt = st_reg.init_cnt - 1'b1;
			end
		end

		// register writes; status and one-shot locations store nothing
		if (cmd_valid && cmd_write) begin
			if (cmd_addr == OFF_CONFIG) begin
				st_next.standby = cmd_wdata[CFG_STANDBY_BIT];
			end else if (cmd_addr == OFF_CONV_ENABLE) begin
				st_next.enables = cmd_wdata[2:0];
			end else if (cmd_addr == OFF_FILTER) begin
				// a reserved code is stored as written; the host keeps
				// clear of it
				st_next.filter = cmd_wdata[3:0];
			end
		end

		// results of a finished slot; done rises as chan already moves on,
		// so the finished channel is the one held a cycle earlier
		if (seq_done) begin
			if (st_reg.last_chan == CH_REMOTE_ONE) begin
				st_next.fault[FAULT_R1_OPEN:FAULT_R1_SHORT] =
					classify(st_reg.sense_s2[1:0]);
				st_next.r1_signed = signed_reading(measured_temp,
					|st_next.fault[FAULT_R1_OPEN:FAULT_R1_SHORT]);
				st_next.r1_unsigned = unsigned_reading(measured_temp,
					|st_next.fault[FAULT_R1_OPEN:FAULT_R1_SHORT]);
			end else if (st_reg.last_chan == CH_REMOTE_TWO) begin
				st_next.fault[FAULT_R2_OPEN:FAULT_R2_SHORT] =
					classify(st_reg.sense_s2[3:2]);
				st_next.r2_signed = signed_reading(measured_temp,
					|st_next.fault[FAULT_R2_OPEN:FAULT_R2_SHORT]);
				st_next.r2_unsigned = unsigned_reading(measured_temp,
					|st_next.fault[FAULT_R2_OPEN:FAULT_R2_SHORT]);
			end
			// summary uses the fault bits just written, so it never lags
			st_next.summary = {|crit_three_status, |crit_two_status,
				|crit_one_status, |st_next.fault};
		end

		// read decode; unmapped and write-only locations answer zero
		if (cmd_addr == OFF_COMMON_STATUS) begin
			read_data[STAT_BUSY_BIT] = seq_busy;
			read_data[STAT_NR_BIT] = st_reg.init_pending;
			read_data[3:0] = st_reg.summary;
		end else if (cmd_addr == OFF_CONFIG) begin
			read_data[CFG_STANDBY_BIT] = st_reg.standby;
		end else if (cmd_addr == OFF_CONV_ENABLE) begin
			read_data[2:0] = st_reg.enables;
		end else if (cmd_addr == OFF_FILTER) begin
			read_data[3:0] = st_reg.filter;
		end else if (cmd_addr == OFF_DIODE_FAULT) begin
			read_data[3:0] = st_reg.fault;
		end
	end

	// power-on values are all constants
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.init_cnt <= IW'(INIT_CYCLES - 1);
			st_reg.init_pending <= 1'b1;
			st_reg.standby <= CONFIG_RESET[CFG_STANDBY_BIT];
			st_reg.enables <= ENABLE_RESET[2:0];
			st_reg.filter <= FILTER_RESET[3:0];
			st_reg.fault <= STATUS_RESET[3:0];
			st_reg.summary <= STATUS_RESET[3:0];
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops
	assign conv_busy = seq_busy;
	assign conv_channel = seq_chan;
	assign low_power_hold_bit = st_reg.standby;
	assign powerup_init_pending = st_reg.init_pending;
	assign remote_one_filter_select = st_reg.filter[FILT_R1_LSB +: 2];
	assign remote_two_filter_select = st_reg.filter[FILT_R2_LSB +: 2];
	assign remote_one_signed_result = st_reg.r1_signed;
	assign remote_one_unsigned_result = st_reg.r1_unsigned;
	assign remote_two_signed_result = st_reg.r2_signed;
	assign remote_two_unsigned_result = st_reg.r2_unsigned;

endmodule

// >>> tb/temp_regs_props.sv
// port-level checker of the temperature register block
// bound into every instance of the block at the foot of this file
`timescale 1ns/1ps

module temp_regs_props
	import temp_regs_pkg::*;
#(
	parameter int INIT_CYCLES = 20,
	parameter int CONV_CYCLES = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_busy,
	input wire logic conv_busy,
	input wire logic [1:0] conv_channel,
	input wire logic low_power_hold_bit,
	input wire logic powerup_init_pending,
	input wire logic [1:0] remote_one_filter_select,
	input wire logic [1:0] remote_two_filter_select,
	input wire logic signed [SRES_W-1:0] remote_one_signed_result,
	input wire logic [URES_W-1:0] remote_one_unsigned_result
);
	int init_cnt;
	int slot_cnt;
	logic busy_q;
	logic [1:0] ch_q;

	// cycles since reset release, and busy cycles in the running slot
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_cnt <= 0;
			slot_cnt <= 0;
			busy_q <= 1'b0;
			ch_q <= 2'h0;
		end else begin
			if (init_cnt < INIT_CYCLES + 4)
				init_cnt <= init_cnt + 1;
			if (conv_busy && (!busy_q || conv_channel != ch_q))
				slot_cnt <= 1;
			else if (conv_busy)
				slot_cnt <= slot_cnt + 1;
			else
				slot_cnt <= 0;
			busy_q <= conv_busy;
			ch_q <= conv_channel;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// one cycle of slack before the drop and two after: the release edge is not counted alike
	property p_init_hi; init_cnt < INIT_CYCLES - 1 |-> powerup_init_pending;
	endproperty
	a_init_hi: assert property (p_init_hi)
		else $error("init ended early");
	property p_init_lo; init_cnt > INIT_CYCLES + 1 |-> !powerup_init_pending;
	endproperty
	a_init_lo: assert property (p_init_lo) else $error("init too long");
	property p_init_idle; powerup_init_pending |-> !conv_busy; endproperty
	a_init_idle: assert property (p_init_idle)
		else $error("converting in init");
	property p_slot_len;
		busy_q && (!conv_busy || conv_channel != ch_q) |-> slot_cnt == CONV_CYCLES;
	endproperty
	a_slot_len: assert property (p_slot_len)
		else $error("slot length");
	property p_cont; $fell(conv_busy) && !low_power_hold_bit |=> conv_busy;
	endproperty
	a_cont: assert property (p_cont) else $error("no restart");
	property p_hold;
		low_power_hold_bit && !conv_busy && !link_busy |=> !conv_busy;
	endproperty
	a_hold: assert property (p_hold)
		else $error("standby pass unasked");
	property p_filt;
		!$stable({remote_one_filter_select, remote_two_filter_select}) |-> link_busy;
	endproperty
	a_filt: assert property (p_filt) else $error("filter moved alone");
	property p_fault; remote_one_signed_result == SIGNED_FAULT_RESULT
		|-> remote_one_unsigned_result == UNSIGNED_FAULT_RESULT; endproperty
	a_fault: assert property (p_fault) else $error("fault reading");

	c_shot: cover property (low_power_hold_bit && $rose(conv_busy));
	c_cont: cover property ($fell(conv_busy) ##1 conv_busy);
	c_fault: cover property (remote_one_signed_result == SIGNED_FAULT_RESULT);
endmodule

bind temp_sensor_filter_status_regs temp_regs_props #(
	.INIT_CYCLES(INIT_CYCLES), .CONV_CYCLES(CONV_CYCLES)) i_props (.*);

// >>> tb/smbus_host_model.sv
// host side of the register link, one command byte at a time
// assumes link_clk runs free and an answer within 20 link cycles
`timescale 1ns/1ps

module smbus_host_model (
	input wire logic link_clk,
	input wire logic link_busy,
	input wire logic link_done,
	input wire logic [7:0] link_rdata,
	output logic link_req,
	output logic link_write,
	output logic [7:0] link_cmd,
	output logic [7:0] link_wdata
);
	// idle levels before the first transfer
	initial begin
		link_req = 1'b0;
		link_write = 1'b0;
		link_cmd = 8'h00;
		link_wdata = 8'h00;
	end

	// request pulses for the taking edge only: a request still high
	// at the done edge would be taken a second time
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [7:0] d, output logic [7:0] r, output logic ok);
		int n;
		ok = 1'b0;
		r = 8'h00;
		@(posedge link_clk);
		link_req <= 1'b1;
		link_write <= w;
		link_cmd <= c;
		link_wdata <= d;
		@(posedge link_clk);
		link_req <= 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge link_clk);
			if (link_done === 1'b1) begin
				ok = 1'b1;
				r = link_rdata;
			end
		end
		// released fields show the inverse, never a stale copy
		link_write <= ~w;
		link_cmd <= ~c;
		link_wdata <= ~d;
	endtask
endmodule

// >>> tb/temp_sensor_filter_status_regs_tb.sv
// self-checking bench of the temperature register block
// assumes the host model on the link and shortened init and slot counts
`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	miscompares++; $display("wrong value at %0t: %h not %h", \
	$time, (a), (b)); end end

module temp_sensor_filter_status_regs_tb;
	import temp_regs_pkg::*;
	localparam int INIT_N = 200;
	localparam int CONV_N = 12;
	logic sys_clk, sys_rst, link_clk;
	logic link_req, link_write, link_busy, link_done;
	logic [7:0] link_cmd, link_wdata, link_rdata;
	logic remote_one_short_sense, remote_one_open_sense;
	logic remote_two_short_sense, remote_two_open_sense;
	logic signed [TEMP_W-1:0] measured_temp;
	logic [2:0] crit_one_status, crit_two_status, crit_three_status;
	logic conv_busy, low_power_hold_bit, powerup_init_pending;
	logic [1:0] conv_channel, remote_one_filter_select;
	logic [1:0] remote_two_filter_select;
	logic signed [SRES_W-1:0] remote_one_signed_result;
	logic signed [SRES_W-1:0] remote_two_signed_result;
	logic [URES_W-1:0] remote_one_unsigned_result;
	logic [URES_W-1:0] remote_two_unsigned_result;
	int miscompares, comparisons;

	temp_sensor_filter_status_regs #(.INIT_CYCLES(INIT_N),
		.CONV_CYCLES(CONV_N)) i_dut (.*);
	smbus_host_model i_host (.*);

	// free clocks, the link one offset so the phases never line up
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end

	// running totals of busy cycles and of local slot cycles; sampled
	// mid-cycle so each settled cycle counts once
	int busy_total = 0;
	int local_total = 0;
	always @(negedge sys_clk) begin
		if (conv_busy === 1'b1) begin
			busy_total <= busy_total + 1;
			if (conv_channel === CH_LOCAL)
				local_total <= local_total + 1;
		end
	end

	task automatic end_of_test;
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic fail;
		miscompares++;
		$display("wrong value at %0t: timed out", $time);
		end_of_test;
	endtask

	// one link transfer; a missing answer ends the run
	task automatic xf(input logic w, input logic [7:0] c, input logic [7:0] d,
		output logic [7:0] v);
		logic ok;
		i_host.xfer(w, c, d, v, ok);
		if (ok !== 1'b1)
			fail;
	endtask

	task automatic wait_busy(input logic lvl);
		int n;
		for (n = 0; n < 1000 && conv_busy !== lvl; n++)
			@(negedge sys_clk);
		if (conv_busy !== lvl)
			fail;
	endtask

	task automatic t_reset;
		logic [7:0] v;
		xf(1'b0, OFF_COMMON_STATUS, 8'h00, v);
		`CHK(v, 8'h40)
		xf(1'b0, OFF_FILTER, 8'h00, v);
		`CHK(v, 8'h0f)
		`CHK(remote_two_filter_select, 2'h3)
		$display("reset values done");
	endtask

	// continuous passes after init raise the busy bit, which drops for a cycle between passes
	task automatic t_busy;
		logic [7:0] v_busy;
		int n;
		for (n = 0; n < 400 && powerup_init_pending !== 1'b0; n++)
			@(negedge sys_clk);
		`CHK(powerup_init_pending, 1'b0)
		wait_busy(1'b1);
		xf(1'b0, OFF_COMMON_STATUS, 8'h00, v_busy);
		`CHK(v_busy, 8'h80)
		wait_busy(1'b0);
		wait_busy(1'b1);
		$display("busy flag done");
	endtask

	// code 10 is never written into a field, the host must avoid it
	task automatic t_filter;
		logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
		logic [7:0] v;
		for (int i = 0; i < 3; i++) begin
			xf(1'b1, OFF_FILTER, {4'hf, codes[i], codes[(i + 1) % 3]}, v);
			xf(1'b0, OFF_FILTER, 8'h00, v);
			`CHK(v, {4'h0, codes[i], codes[(i + 1) % 3]})
			`CHK(remote_two_filter_select, codes[i])
			`CHK(remote_one_filter_select, codes[(i + 1) % 3])
		end
		$display("filter codes done");
	endtask

	// standby, local disabled, then one single pass from a trigger write
	task automatic t_oneshot;
		logic [7:0] v;
		int b0, l0;
		xf(1'b1, OFF_CONFIG, 8'h40, v);
		xf(1'b0, OFF_CONFIG, 8'h00, v);
		`CHK(v, 8'h40)
		`CHK(low_power_hold_bit, 1'b1)
		wait_busy(1'b0);
		xf(1'b1, OFF_CONV_ENABLE, 8'h06, v);
		b0 = busy_total;
		l0 = local_total;
		xf(1'b1, OFF_ONESHOT, 8'ha5, v);
		wait_busy(1'b0);
		xf(1'b0, OFF_ONESHOT, 8'h00, v);
		`CHK(v, 8'h00)
		// long enough for a second pass to show if one were started
		repeat (3 * CONV_N) @(negedge sys_clk);
		`CHK(local_total - l0, 0)
		`CHK(busy_total - b0, 2 * CONV_N)
		`CHK(conv_busy, 1'b0)
		$display("one-shot done");
	endtask

	// f is {r2 open, r2 short, r1 open, r1 short}, c is {crit3, crit2, crit1}
	task automatic t_fault(input logic [3:0] f, input logic [8:0] c);
		logic [7:0] v;
		logic [10:0] s1, s2, u1, u2;
		s1 = (f[1:0] != 2'h0) ? 11'h400 : 11'd200;
		s2 = (f[3:2] != 2'h0) ? 11'h400 : 11'd200;
		u1 = (f[1:0] != 2'h0) ? 11'h000 : 11'd200;
		u2 = (f[3:2] != 2'h0) ? 11'h000 : 11'd200;
		@(posedge sys_clk);
		remote_one_short_sense <= f[0];
		remote_one_open_sense <= f[1];
		remote_two_short_sense <= f[2];
		remote_two_open_sense <= f[3];
		{crit_three_status, crit_two_status, crit_one_status} <= c;
		xf(1'b1, OFF_ONESHOT, 8'h00, v);
		wait_busy(1'b0);
		xf(1'b1, OFF_DIODE_FAULT, 8'hff, v);
		xf(1'b0, OFF_DIODE_FAULT, 8'h00, v);
		`CHK(v, {4'h0, f})
		xf(1'b0, OFF_COMMON_STATUS, 8'h00, v);
		`CHK(v, {4'h0, |c[8:6], |c[5:3], |c[2:0], |f})
		`CHK(remote_one_signed_result, s1)
		`CHK(remote_two_signed_result, s2)
		`CHK(remote_one_unsigned_result, u1)
		`CHK(remote_two_unsigned_result, u2)
		$display("fault case done");
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		remote_one_short_sense = 1'b0;
		remote_one_open_sense = 1'b0;
		remote_two_short_sense = 1'b0;
		remote_two_open_sense = 1'b0;
		measured_temp = 12'sd200;
		crit_one_status = 3'h0;
		crit_two_status = 3'h0;
		crit_three_status = 3'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset;
		t_busy;
		t_filter;
		t_oneshot;
		t_fault(4'h9, 9'h010);
		t_fault(4'h6, 9'h101);
		t_fault(4'h0, 9'h000);
		end_of_test;
	end
endmodule
